// *** rtl/slc_regs.svh ***
// Constants of the serial LED channel latch: channel count, reset values,
// buffer depth, fill mark, cascade delay and the levels of undriven pins.
// Assumes nothing; holds definitions only and is included by bare name.
`ifndef SLC_REGS_SVH
`define SLC_REGS_SVH

// =====================================================================
// Channel layout
`define SLC_NUM_CH 10
`define SLC_LAST_CH 9
`define SLC_CHAN_RST 10'h000

// =====================================================================
// Crossing and buffering
`define SLC_FIFO_DEPTH 8
`define SLC_FILL_MARK 4'h7
`define SLC_CASCADE_DELAY 4'hA

// =====================================================================
// Levels seen on a control pin that nobody drives
`define SLC_LATCH_FLOAT_LVL 1'b0
`define SLC_ALL_OFF_FLOAT_LVL 1'b1

`endif

// *** rtl/slc_pkg.sv ***
// Types shared by the serial LED channel latch modules.
// Assumes slc_regs.svh is on the include path.
`include "slc_regs.svh"

package slc_pkg;
    // One bit per LED channel, bit 0 is channel zero.
    typedef logic [`SLC_NUM_CH-1:0] slc_chan_t;

    // Control pins after pull resolution, carried together across clocks.
    typedef struct packed {
        logic latch;
        logic all_off;
        logic over_volt;
    } slc_ctrl_t;
endpackage : slc_pkg

// *** rtl/slc_sync.sv ***
// Two-flop level synchroniser, one pair of flops per bit.
// Assumes the inputs are levels or gray-coded words that move one bit at a time.
`timescale 1ns/100ps

module slc_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    // =================================================================
    // Per-bit stages
    for (genvar i = 0; i < W; i++) begin : g_bit
        logic meta_reg;
        logic hold_reg;

        // The first flop is read only by the second one.
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                meta_reg <= 1'b0;
                hold_reg <= 1'b0;
            end else begin
                meta_reg <= d[i];
                hold_reg <= meta_reg;
            end
        end

        assign q[i] = hold_reg;
    end
endmodule : slc_sync

// *** rtl/slc_fifo.sv ***
// Dual-clock FIFO with gray-coded pointers, valid and ready on both sides.
// Assumes D is a power of two of at least four and both resets are asynchronous.
`timescale 1ns/100ps

module slc_fifo #(
    parameter int W = 10,
    parameter int D = 8
) (
    input wire logic wclk,
    input wire logic wrst_n,
    input wire logic w_valid,
    output logic w_ready,
    input wire logic [W-1:0] w_data,
    input wire logic rclk,
    input wire logic rrst_n,
    output logic r_valid,
    input wire logic r_ready,
    output logic [W-1:0] r_data,
    output logic [$clog2(D):0] r_level
);
    localparam int AW = $clog2(D);
    localparam int PW = AW + 1;

    logic [W-1:0] mem [D];
    logic [PW-1:0] wbin_reg, wgray_reg, rbin_reg, rgray_reg;
    logic [PW-1:0] wgray_s, rgray_s, wbin_next, rbin_next, wbin_s;

    // Convert a synchronised gray pointer back to binary for the fill level.
    function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
        logic [PW-1:0] b;
        b[PW-1] = g[PW-1];
        for (int i = PW - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction : gray2bin

    // =================================================================
    // Pointer crossings
    slc_sync #(.W(PW)) u_rptr_sync (.clk(wclk), .rst_n(wrst_n), .d(rgray_reg), .q(rgray_s));
    slc_sync #(.W(PW)) u_wptr_sync (.clk(rclk), .rst_n(rrst_n), .d(wgray_reg), .q(wgray_s));

    // =================================================================
    // Write side: full is judged against a stale read pointer, so it is safe.
    assign w_ready = (wgray_reg != {~rgray_s[PW-1:PW-2], rgray_s[PW-3:0]});
    assign wbin_next = wbin_reg + 1'b1;

    always_ff @(posedge wclk or negedge wrst_n) begin
        if (!wrst_n) begin
            wbin_reg <= '0;
            wgray_reg <= '0;
        end else if (w_valid && w_ready) begin
            wbin_reg <= wbin_next;
            wgray_reg <= wbin_next ^ (wbin_next >> 1);
        end
    end

    // Storage carries no reset; an entry is read only after it was written.
    always_ff @(posedge wclk) begin
        if (w_valid && w_ready) begin
            mem[wbin_reg[AW-1:0]] <= w_data;
        end
    end

    // =================================================================
    // Read side
    assign r_valid = (rgray_reg != wgray_s);
    assign r_data = mem[rbin_reg[AW-1:0]];
    assign rbin_next = rbin_reg + 1'b1;
    assign wbin_s = gray2bin(wgray_s);
    assign r_level = wbin_s - rbin_reg;

    always_ff @(posedge rclk or negedge rrst_n) begin
        if (!rrst_n) begin
            rbin_reg <= '0;
            rgray_reg <= '0;
        end else if (r_valid && r_ready) begin
            rbin_reg <= rbin_next;
            rgray_reg <= rbin_next ^ (rbin_next >> 1);
        end
    end
endmodule : slc_fifo

// *** rtl/slc_channel_latch.sv ***
// Ten-channel serial-in, parallel-out control logic of an LED switch driver.
// Assumes nrst is the under-voltage lockout reset, sclk comes from the host,
// and the pad ring tells whether the latch and all-off pins are driven.
`timescale 1ns/100ps
`include "slc_regs.svh"

module slc_channel_latch (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic serial_data_in,
    input wire logic latch_control,
    input wire logic latch_control_float,
    input wire logic all_off,
    input wire logic all_off_float,
    input wire logic battery_sense,
    output logic cascade_out,
    output logic snapshot_ready,
    input wire logic [`SLC_NUM_CH-1:0] channel_switches_i,
    output logic [`SLC_NUM_CH-1:0] channel_switches_o,
    output logic [`SLC_NUM_CH-1:0] channel_switches_oe,
    output logic switch_fault
);
    // =================================================================
    // Declarations
    slc_pkg::slc_chan_t shift_reg;
    slc_pkg::slc_chan_t shift_next;
    slc_pkg::slc_chan_t fifo_rd_data;
    slc_pkg::slc_chan_t shadow_reg;
    slc_pkg::slc_chan_t chan_latch_reg;
    slc_pkg::slc_chan_t switch_en_reg;
    slc_pkg::slc_chan_t switch_en_next;
    slc_pkg::slc_ctrl_t ctrl_pin;
    slc_pkg::slc_ctrl_t ctrl_q;
    logic fifo_wr_valid;
    logic fifo_wr_ready;
    logic fifo_rd_valid;
    logic fifo_rd_ready;
    logic [3:0] fifo_level;
    logic started_reg;
    logic fault_reg;
    logic [3:0] fill_cnt_reg;

    // =================================================================
    // Link domain: shift register on the host's shift clock

    // The newest bit enters stage zero and the oldest leaves at stage nine.
    assign shift_next = {shift_reg[`SLC_LAST_CH-1:0], serial_data_in};

    // Power-up and lockout clear the register; each edge moves it one stage.
    always_ff @(posedge sclk or negedge nrst) begin
        if (!nrst) begin
            shift_reg <= `SLC_CHAN_RST;
        end else begin
            shift_reg <= shift_next;
        end
    end

    // The cascade pin is the last stage itself, so it moves with the shift.
    assign cascade_out = shift_reg[`SLC_LAST_CH];

    // Marks the first edge after reset; only the shift-step check reads it, snapshots are always offered.
    always_ff @(posedge sclk or negedge nrst) begin
        if (!nrst) begin
            started_reg <= 1'b0;
        end else begin
            started_reg <= 1'b1;
        end
    end

    // Each edge offers the post-shift word, so the final shift of a frame is
    // captured on its own edge and needs no trailing clock that may never come.
    assign fifo_wr_valid = 1'b1;
    assign snapshot_ready = fifo_wr_ready;

    // Counts edges since reset, saturating at the cascade delay.
    always_ff @(posedge sclk or negedge nrst) begin
        if (!nrst) begin
            fill_cnt_reg <= 4'h0;
        end else if (fill_cnt_reg != `SLC_CASCADE_DELAY) begin
            fill_cnt_reg <= fill_cnt_reg + 4'h1;
        end
    end

    // =================================================================
    // Snapshot buffer between the link domain and the system domain

    // Gray pointers cross inside; the drain side never stalls, so it stays far from full.
    slc_fifo #(
        .W(`SLC_NUM_CH),
        .D(`SLC_FIFO_DEPTH)
    ) u_fifo (
        .wclk(sclk),
        .wrst_n(nrst),
        .w_valid(fifo_wr_valid),
        .w_ready(fifo_wr_ready),
        .w_data(shift_next),
        .rclk(mclk),
        .rrst_n(nrst),
        .r_valid(fifo_rd_valid),
        .r_ready(fifo_rd_ready),
        .r_data(fifo_rd_data),
        .r_level(fifo_level)
    );

    // =================================================================
    // Control pins: pull resolution, then two flops into mclk

    // A floating latch pin reads low and a floating all-off pin reads high.
    always_comb begin
        ctrl_pin.latch = latch_control_float ? `SLC_LATCH_FLOAT_LVL : latch_control;
        ctrl_pin.all_off = all_off_float ? `SLC_ALL_OFF_FLOAT_LVL : all_off;
        ctrl_pin.over_volt = battery_sense;
    end

    slc_sync #(
        .W($bits(slc_pkg::slc_ctrl_t))
    ) u_ctrl_sync (
        .clk(mclk),
        .rst_n(nrst),
        .d(ctrl_pin),
        .q(ctrl_q)
    );

    // =================================================================
    // System domain: draining snapshots and the channel latches

    // Always drain, so the shadow tracks the newest word and the link side never
    // sees full. Holding back here would let the stale read pointer on the link
    // side refuse the last shift of a frame, which a stopped clock never retries.
    assign fifo_rd_ready = 1'b1;

    // The shadow holds the newest shift register word seen on this side.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            shadow_reg <= `SLC_CHAN_RST;
        end else if (fifo_rd_valid && fifo_rd_ready) begin
            shadow_reg <= fifo_rd_data;
        end
    end

    // Transparent while latch control is high, frozen while it is low.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            chan_latch_reg <= `SLC_CHAN_RST;
        end else if (ctrl_q.latch) begin
            chan_latch_reg <= shadow_reg;
        end
    end

    // =================================================================
    // Switch drive

    // A latched one sinks current unless all-off or over-voltage blanks it.
    assign switch_en_next = (ctrl_q.all_off || ctrl_q.over_volt) ? `SLC_CHAN_RST : chan_latch_reg;

    // Registered enables; recovery after over-voltage needs no host action.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            switch_en_reg <= `SLC_CHAN_RST;
        end else begin
            switch_en_reg <= switch_en_next;
        end
    end

    // Open-drain: the pin only ever sinks, so the data level is a fixed low.
    assign channel_switches_o = `SLC_CHAN_RST;
    assign channel_switches_oe = switch_en_reg;

    // A switch that is sinking but still sees a high pin points at a fault.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            fault_reg <= 1'b0;
        end else begin
            fault_reg <= |(switch_en_reg & channel_switches_i);
        end
    end

    assign switch_fault = fault_reg;

    // =================================================================
    // Checks on the link domain

    // Every stage takes its neighbour's old value; stage zero takes the pin.
    a_shift_step: assert property (@(posedge sclk) disable iff (!nrst)
        started_reg |-> (shift_reg[`SLC_LAST_CH:1] == $past(shift_reg[`SLC_LAST_CH-1:0]))
            && (shift_reg[0] == $past(serial_data_in)))
        else $error("shift register did not advance by one stage");

    // The oldest of the last ten bits reaches the cascade pin at stage nine.
    a_cascade_delay: assert property (@(posedge sclk) disable iff (!nrst)
        (fill_cnt_reg == `SLC_CASCADE_DELAY) |-> (cascade_out == $past(serial_data_in, 10)))
        else $error("cascade output is not the input delayed by ten clocks");

    // The first bit shifted lands on cascade after exactly nine more edges.
    a_cascade_first: assert property (@(posedge sclk) disable iff (!nrst)
        (fill_cnt_reg == 4'h1) |-> ##9 (cascade_out == $past(serial_data_in, 10)))
        else $error("first shifted bit did not reach the cascade output");

    // =================================================================
    // Checks on the system domain

    // Lockout keeps both shift register and channel latches at zero.
    a_power_clear: assert property (@(posedge mclk)
        !nrst |-> (shift_reg == `SLC_CHAN_RST) && (chan_latch_reg == `SLC_CHAN_RST)
            && (channel_switches_oe == `SLC_CHAN_RST))
        else $error("state not cleared during lockout");

    // A held latch does not move, whatever arrives from the link.
    a_latch_hold: assert property (@(posedge mclk) disable iff (!nrst)
        !ctrl_q.latch [*2] |-> $stable(chan_latch_reg))
        else $error("channel latch changed while holding");

    // A transparent latch shows the shadow word one cycle later.
    a_latch_follow: assert property (@(posedge mclk) disable iff (!nrst)
        ctrl_q.latch |=> (chan_latch_reg == $past(shadow_reg)))
        else $error("channel latch did not follow the shift register");

    // A freely drained buffer never comes near full, so no snapshot is refused.
    a_snap_room: assert property (@(posedge mclk) disable iff (!nrst)
        fifo_level < `SLC_FILL_MARK)
        else $error("snapshot buffer filled up");

    // A floating latch pin reads low after the two synchroniser flops.
    a_float_latch: assert property (@(posedge mclk) disable iff (!nrst)
        latch_control_float [*3] |-> !ctrl_q.latch)
        else $error("floating latch control did not read low");

    // All-off blanks every switch on the next edge.
    a_all_off_blank: assert property (@(posedge mclk) disable iff (!nrst)
        ctrl_q.all_off |=> (channel_switches_oe == `SLC_CHAN_RST))
        else $error("switch enabled while all-off is high");

    // Over-voltage blanks every switch within three edges of the pin.
    a_ov_blank: assert property (@(posedge mclk) disable iff (!nrst)
        battery_sense [*3] |=> (channel_switches_oe == `SLC_CHAN_RST))
        else $error("switch enabled during over-voltage");

    // With neither blanking cause, the switches show the latched bits.
    a_ov_recover: assert property (@(posedge mclk) disable iff (!nrst)
        (!ctrl_q.all_off && !ctrl_q.over_volt) |=> (channel_switches_oe == $past(chan_latch_reg)))
        else $error("switches did not follow the latches");

endmodule : slc_channel_latch

// *** verif/slc_host_model.sv ***
// Host controller model: makes the shift clock and the serial data stream.
// Assumes the bench calls shift_bit once per bit; the clock stands low between calls.
`timescale 1ns/100ps

// ==========================================================
// Host side of the serial link
module slc_host_model (
    output logic sclk,
    output logic serial_data_in
);
    // Idle levels at time zero; the clock only runs inside frames.
    initial begin
        sclk = 1'b0;
        serial_data_in = 1'b0;
    end

    // One 160 ns shift clock period; odd offsets keep the rising edge off the system clock grid.
    // After the falling edge the data line shows the inverse, so a stale bit is never read as good.
    task automatic shift_bit(input logic b);
        serial_data_in = b;
        #43;
        sclk = 1'b1;
        #80;
        sclk = 1'b0;
        serial_data_in = ~b;
        #37;
    endtask : shift_bit
endmodule : slc_host_model

// *** verif/slc_channel_latch_tb_top.sv ***
// Self-checking bench of the channel latch, with a behavioural model of shift register and latches.
// Assumes the design package and slc_host_model are compiled first.
`timescale 1ns/100ps

// ==========================================================
// Bench top
module slc_channel_latch_tb_top;
    logic mclk;
    logic nrst;
    logic sclk;
    logic serial_data_in;
    logic latch_control;
    logic latch_control_float;
    logic all_off;
    logic all_off_float;
    logic battery_sense;
    logic cascade_out;
    logic snapshot_ready;
    slc_pkg::slc_chan_t sw_i;
    slc_pkg::slc_chan_t sw_o;
    slc_pkg::slc_chan_t sw_oe;
    logic switch_fault;
    int failures;
    int checks_done;
    logic [9:0] m_sreg;
    logic [9:0] m_lat;
    logic [9:0] w;
    logic fault_inj;

    // Open-drain readback: a sinking switch pulls its pin low, unless a fault holds it high.
    assign sw_i = ~sw_oe | {10{fault_inj}};

    slc_host_model host (.sclk(sclk), .serial_data_in(serial_data_in));

    slc_channel_latch DUT (
        .mclk(mclk), .nrst(nrst), .sclk(sclk), .serial_data_in(serial_data_in),
        .latch_control(latch_control), .latch_control_float(latch_control_float),
        .all_off(all_off), .all_off_float(all_off_float), .battery_sense(battery_sense),
        .cascade_out(cascade_out), .snapshot_ready(snapshot_ready),
        .channel_switches_i(sw_i), .channel_switches_o(sw_o),
        .channel_switches_oe(sw_oe), .switch_fault(switch_fault)
    );

    // System clock, 20 ns period.
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // ==========================================================
    // Checking and closing
    task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // Expected switches: latched bit gated by both off conditions; a floating all-off pin reads high.
    function automatic logic [9:0] exp_oe();
        if ((all_off_float | all_off) | battery_sense) begin
            return 10'h000;
        end
        return m_lat;
    endfunction : exp_oe

    // Channel nine first; the cascade pin is compared after every shift edge.
    task automatic frame(input logic [9:0] v);
        for (int i = 9; i >= 0; i--) begin
            host.shift_bit(v[i]);
            m_sreg = {m_sreg[8:0], v[i]};
            chk(10'(cascade_out), 10'(m_sreg[9]));
        end
    endtask : frame

    // Waits out the crossing, then pulses the latch pin for eight cycles.
    task automatic latch_pulse();
        repeat (20) @(negedge mclk);
        latch_control = 1'b1;
        if (!latch_control_float) begin
            m_lat = m_sreg;
        end
        repeat (8) @(negedge mclk);
        latch_control = 1'b0;
    endtask : latch_pulse

    task automatic settle_chk();
        repeat (6) @(negedge mclk);
        chk(sw_oe, exp_oe());
        chk(sw_o, 10'h000);
    endtask : settle_chk

    task automatic do_reset();
        nrst = 1'b0;
        m_sreg = 10'h000;
        m_lat = 10'h000;
        repeat (12) @(negedge mclk);
        chk(sw_oe, 10'h000);
        chk(10'(cascade_out), 10'h000);
        nrst = 1'b1;
    endtask : do_reset

    // Watchdog: a hang counts as a mismatch.
    initial begin
        #1500000;
        failures++;
        report_and_stop();
    end

    // ==========================================================
    // Main sequence
    initial begin
        failures = 0;
        checks_done = 0;
        nrst = 1'b1;
        fault_inj = 1'b0;
        latch_control = 1'b0;
        latch_control_float = 1'b0;
        all_off = 1'b0;
        all_off_float = 1'b0;
        battery_sense = 1'b0;
        w = 10'($urandom(34471));
        // Let the reset processes arm before the first falling reset edge.
        #1;
        do_reset();
        chk(10'(snapshot_ready), 10'h001);
        $display("test reset done");

        // Single-channel patterns place the first and last bit, then random words.
        for (int k = 0; k < 5; k++) begin
            w = (k == 0) ? 10'h001 : (k == 1) ? 10'h200 : 10'($urandom());
            frame(w);
            latch_pulse();
            settle_chk();
        end
        $display("test load done");

        // Shifting with the latch low must leave the switches alone.
        frame(~m_lat);
        settle_chk();
        // Floating latch pin reads low even with the pin level high.
        latch_control_float = 1'b1;
        latch_pulse();
        settle_chk();
        latch_control_float = 1'b0;
        $display("test hold done");

        // All-off driven high, then floating, then released.
        all_off = 1'b1;
        settle_chk();
        all_off = 1'b0;
        all_off_float = 1'b1;
        settle_chk();
        all_off_float = 1'b0;
        settle_chk();
        // Over-voltage forces off and recovers with no host action.
        battery_sense = 1'b1;
        settle_chk();
        battery_sense = 1'b0;
        settle_chk();
        $display("test off done");

        // Two devices in a chain: twenty shifts, one latch pulse.
        frame(10'($urandom()));
        frame(10'($urandom()));
        latch_pulse();
        settle_chk();
        $display("test chain done");

        // A sinking switch whose pin stays high raises the fault flag one cycle later.
        fault_inj = 1'b1;
        repeat (2) @(negedge mclk);
        chk(10'(switch_fault), 10'(exp_oe() != 10'h000));
        fault_inj = 1'b0;
        repeat (2) @(negedge mclk);
        chk(10'(switch_fault), 10'h000);
        $display("test fault done");

        // Reset in mid-run clears everything; the next frame shifts out zeros.
        do_reset();
        frame(10'h3FF);
        chk(10'(switch_fault), 10'h000);
        $display("test rereset done");
        report_and_stop();
    end
endmodule : slc_channel_latch_tb_top
